// File: rtl/ogc_map.svh
// register map, field positions and constants for the overlay gamma unit
`ifndef OGC_MAP_SVH
`define OGC_MAP_SVH

`define OGC_ADDR_PT192 20'h30010
`define OGC_ADDR_PT128 20'h30014
`define OGC_ADDR_PT64 20'h30018
`define OGC_ADDR_PT32 20'h3001C
`define OGC_ADDR_PT16 20'h30020
`define OGC_ADDR_PT8 20'h30024

`define OGC_RST_PT192 24'hC0C0C0
`define OGC_RST_PT128 24'h808080
`define OGC_RST_PT64 24'h404040
`define OGC_RST_PT32 24'h202020
`define OGC_RST_PT16 24'h101010
`define OGC_RST_PT8 24'h080808

`define OGC_LANE_W 8
`define OGC_RED_LSB 16
`define OGC_GREEN_LSB 8
`define OGC_BLUE_LSB 0
`define OGC_RSVD_W 8

`define OGC_X_8 8'h08
`define OGC_X_16 8'h10
`define OGC_X_32 8'h20
`define OGC_X_64 8'h40
`define OGC_X_128 8'h80
`define OGC_X_192 8'hC0
`define OGC_TOP_END 9'h100
`define OGC_POST_SHIFT 7
`define OGC_SH_1 3'h1
`define OGC_SH_2 3'h2
`define OGC_SH_3 3'h3
`define OGC_SH_4 3'h4

`define OGC_SEG_ZERO 3'h0
`define OGC_SEG_8 3'h1
`define OGC_SEG_16 3'h2
`define OGC_SEG_32 3'h3
`define OGC_SEG_64 3'h4
`define OGC_SEG_128 3'h5
`define OGC_SEG_192 3'h6

`endif

// File: rtl/ogc_pkg.sv
// types shared by the overlay gamma unit
package ogc_pkg;
  typedef logic [7:0] ogc_comp_t;
  typedef logic [8:0] ogc_slope_t;
  typedef logic [6:0] ogc_offs_t;
  typedef logic [23:0] ogc_point_t;
endpackage : ogc_pkg

// File: rtl/ogc_gamma.sv
// overlay gamma correction: breakpoint registers and interpolating datapath
`timescale 1ns/1ps
`include "ogc_map.svh"

module ogc_gamma
  import ogc_pkg::*;
#(
  parameter int ADDR_W = 20
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic pix_in_valid,
  input wire logic [7:0] pix_in_red,
  input wire logic [7:0] pix_in_green,
  input wire logic [7:0] pix_in_blue,
  output logic pix_out_valid,
  output logic [7:0] pix_out_red,
  output logic [7:0] pix_out_green,
  output logic [7:0] pix_out_blue
);

  // index 0 is the point at 8, index 5 the point at 192
  ogc_point_t pt_ff [6];
  logic [31:0] rdata_ff;
  logic rvalid_ff;
  logic [1:0] vld_ff;
  logic [5:0] wsel;
  logic [5:0] rsel;
  ogc_point_t rpoint;
  logic [23:0] pix_in;
  ogc_point_t wpoint;
  logic [31:0] rword;
  ogc_comp_t out_ff [3];

  localparam logic [ADDR_W-1:0] PT_ADDR [6] = '{
    ADDR_W'(`OGC_ADDR_PT8), ADDR_W'(`OGC_ADDR_PT16), ADDR_W'(`OGC_ADDR_PT32),
    ADDR_W'(`OGC_ADDR_PT64), ADDR_W'(`OGC_ADDR_PT128), ADDR_W'(`OGC_ADDR_PT192)};
  localparam ogc_point_t PT_RST [6] = '{
    `OGC_RST_PT8, `OGC_RST_PT16, `OGC_RST_PT32,
    `OGC_RST_PT64, `OGC_RST_PT128, `OGC_RST_PT192};
  localparam int LANE_LSB [3] = '{`OGC_BLUE_LSB, `OGC_GREEN_LSB, `OGC_RED_LSB};

  // write lanes picked out, reserved byte dropped
  always_comb begin
    wpoint = '0;
    wpoint[`OGC_RED_LSB +: `OGC_LANE_W] = reg_wdata[`OGC_RED_LSB +: `OGC_LANE_W];
    wpoint[`OGC_GREEN_LSB +: `OGC_LANE_W] = reg_wdata[`OGC_GREEN_LSB +: `OGC_LANE_W];
    wpoint[`OGC_BLUE_LSB +: `OGC_LANE_W] = reg_wdata[`OGC_BLUE_LSB +: `OGC_LANE_W];
  end

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_pt
      assign wsel[gi] = reg_wr && (reg_addr == PT_ADDR[gi]);
      assign rsel[gi] = reg_addr == PT_ADDR[gi];
      // whole-word write, no shadow copy: lands on live pixels
      always_ff @(posedge core_clk) begin
        if (rst) begin
          pt_ff[gi] <= PT_RST[gi];
        end else if (wsel[gi]) begin
          pt_ff[gi] <= wpoint;
        end
      end
    end
  endgenerate

  always_comb begin
    rpoint = '0;
    for (int i = 0; i < 6; i++) begin
      if (rsel[i]) begin
        rpoint = pt_ff[i];
      end
    end
  end

  // read word, reserved byte forced to zero
  always_comb begin
    rword = '0;
    rword[`OGC_RED_LSB +: `OGC_LANE_W] = rpoint[`OGC_RED_LSB +: `OGC_LANE_W];
    rword[`OGC_GREEN_LSB +: `OGC_LANE_W] = rpoint[`OGC_GREEN_LSB +: `OGC_LANE_W];
    rword[`OGC_BLUE_LSB +: `OGC_LANE_W] = rpoint[`OGC_BLUE_LSB +: `OGC_LANE_W];
  end

  // reserved bits and unmapped addresses read zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_ff <= '0;
    end else if (reg_rd) begin
      rdata_ff <= rword;
    end
  end

  // one-cycle answer pulse per read
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_rd;
    end
  end

  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;

  // two-stage pipeline, valid travels with data
  always_ff @(posedge core_clk) begin
    if (rst) begin
      vld_ff <= '0;
    end else begin
      vld_ff <= {vld_ff[0], pix_in_valid};
    end
  end

  assign pix_in = {pix_in_red, pix_in_green, pix_in_blue};

  generate
    for (gi = 0; gi < 3; gi++) begin : g_comp
      ogc_comp_t x;
      ogc_comp_t lane_pt [6];
      logic [2:0] seg;
      ogc_comp_t base;
      ogc_slope_t nxt;
      ogc_comp_t start;
      logic [2:0] sh;
      ogc_comp_t offs;
      ogc_comp_t offs_sh;
      ogc_slope_t slope;
      ogc_comp_t base_ff;
      ogc_slope_t slope_ff;
      ogc_offs_t offs_ff;
      logic [15:0] prod;
      logic [8:0] scaled;
      logic [8:0] sum;

      assign x = pix_in[LANE_LSB[gi] +: `OGC_LANE_W];

      // own byte lane of every breakpoint
      for (genvar pi = 0; pi < 6; pi++) begin : g_lane
        assign lane_pt[pi] = pt_ff[pi][LANE_LSB[gi] +: `OGC_LANE_W];
      end

      // segment pick by leading bits
      always_comb begin
        seg = `OGC_SEG_ZERO;
        casez (x)
          8'b11??????: begin
            seg = `OGC_SEG_192;
          end
          8'b10??????: begin
            seg = `OGC_SEG_128;
          end
          8'b01??????: begin
            seg = `OGC_SEG_64;
          end
          8'b001?????: begin
            seg = `OGC_SEG_32;
          end
          8'b0001????: begin
            seg = `OGC_SEG_16;
          end
          8'b00001???: begin
            seg = `OGC_SEG_8;
          end
          default: begin
            seg = `OGC_SEG_ZERO;
          end
        endcase
      end

      // lower point of the segment, fixed zero below 8
      always_comb begin
        base = '0;
        case (seg)
          `OGC_SEG_192: begin
            base = lane_pt[5];
          end
          `OGC_SEG_128: begin
            base = lane_pt[4];
          end
          `OGC_SEG_64: begin
            base = lane_pt[3];
          end
          `OGC_SEG_32: begin
            base = lane_pt[2];
          end
          `OGC_SEG_16: begin
            base = lane_pt[1];
          end
          `OGC_SEG_8: begin
            base = lane_pt[0];
          end
          default: begin
            base = '0;
          end
        endcase
      end

      // next point, fetched with the lower one
      // top end 256 keeps the identity curve exact in the top segment
      always_comb begin
        nxt = '0;
        case (seg)
          `OGC_SEG_192: begin
            nxt = `OGC_TOP_END;
          end
          `OGC_SEG_128: begin
            nxt = {1'b0, lane_pt[5]};
          end
          `OGC_SEG_64: begin
            nxt = {1'b0, lane_pt[4]};
          end
          `OGC_SEG_32: begin
            nxt = {1'b0, lane_pt[3]};
          end
          `OGC_SEG_16: begin
            nxt = {1'b0, lane_pt[2]};
          end
          `OGC_SEG_8: begin
            nxt = {1'b0, lane_pt[1]};
          end
          default: begin
            nxt = {1'b0, lane_pt[0]};
          end
        endcase
      end

      // input position where the segment starts
      always_comb begin
        start = '0;
        case (seg)
          `OGC_SEG_192: begin
            start = `OGC_X_192;
          end
          `OGC_SEG_128: begin
            start = `OGC_X_128;
          end
          `OGC_SEG_64: begin
            start = `OGC_X_64;
          end
          `OGC_SEG_32: begin
            start = `OGC_X_32;
          end
          `OGC_SEG_16: begin
            start = `OGC_X_16;
          end
          `OGC_SEG_8: begin
            start = `OGC_X_8;
          end
          default: begin
            start = '0;
          end
        endcase
      end

      // offset pre-shift, wider for narrower segments
      always_comb begin
        sh = `OGC_SH_4;
        case (seg)
          `OGC_SEG_192: begin
            sh = `OGC_SH_1;
          end
          `OGC_SEG_128: begin
            sh = `OGC_SH_1;
          end
          `OGC_SEG_64: begin
            sh = `OGC_SH_1;
          end
          `OGC_SEG_32: begin
            sh = `OGC_SH_2;
          end
          `OGC_SEG_16: begin
            sh = `OGC_SH_3;
          end
          default: begin
            sh = `OGC_SH_4;
          end
        endcase
      end

      assign offs = x - start;
      assign offs_sh = offs << sh;

      // unsigned slope relies on a rising curve
      assign slope = nxt - {1'b0, base};

      // stage one: base of the segment
      always_ff @(posedge core_clk) begin
        if (rst) begin
          base_ff <= '0;
        end else begin
          base_ff <= base;
        end
      end

      // stage one: slope operand
      always_ff @(posedge core_clk) begin
        if (rst) begin
          slope_ff <= '0;
        end else begin
          slope_ff <= slope;
        end
      end

      // stage one: offset, top bit cut to 7 bits
      always_ff @(posedge core_clk) begin
        if (rst) begin
          offs_ff <= '0;
        end else begin
          offs_ff <= ogc_offs_t'(offs_sh);
        end
      end

      assign prod = {7'h00, slope_ff} * {9'h000, offs_ff};
      assign scaled = prod[`OGC_POST_SHIFT +: 9];
      assign sum = {1'b0, base_ff} + scaled;

      // truncate to 8 bits, identity points reproduce input
      always_ff @(posedge core_clk) begin
        if (rst) begin
          out_ff[gi] <= '0;
        end else begin
          out_ff[gi] <= sum[7:0];
        end
      end
    end
  endgenerate

  // corrected pixel toward the dac
  assign pix_out_valid = vld_ff[1];
  assign pix_out_red = out_ff[2];
  assign pix_out_green = out_ff[1];
  assign pix_out_blue = out_ff[0];

endmodule : ogc_gamma

// File: tb/ogc_gamma_props.sv
// assertion checker for the overlay gamma unit
`timescale 1ns/1ps
module ogc_gamma_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic pix_in_valid,
  input wire logic [7:0] pix_in_red,
  input wire logic [7:0] pix_in_blue,
  input wire logic pix_out_valid,
  input wire logic [7:0] pix_out_red,
  input wire logic [7:0] pix_out_blue
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_lat; pix_out_valid == $past(pix_in_valid, 2); endproperty
  a_lat: assert property (p_lat) else $error("pixel latency");
  property p_rd; reg_rd |=> reg_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read answer missing");
  property p_nord; !reg_rd |=> !reg_rvalid; endproperty
  a_nord: assert property (p_nord) else $error("stray read answer");
  property p_rsv; reg_rvalid |-> reg_rdata[31:24] == 8'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_hold; !reg_rvalid |-> $stable(reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_zr; pix_out_valid && $past(pix_in_red, 2) == 8'h00 |-> pix_out_red == 8'h00;
  endproperty
  a_zr: assert property (p_zr) else $error("red zero input");
  property p_zb; pix_out_valid && $past(pix_in_blue, 2) == 8'h00 |-> pix_out_blue == 8'h00;
  endproperty
  a_zb: assert property (p_zb) else $error("blue zero input");
  property p_nz; pix_out_valid && $past(pix_in_blue, 2) >= 8'h08 |-> pix_out_blue != 8'h00;
  endproperty
  a_nz: assert property (p_nz) else $error("blue above low point");
endmodule : ogc_gamma_props

bind ogc_gamma ogc_gamma_props u_props (.core_clk(core_clk), .rst(rst), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pix_in_valid(pix_in_valid),
  .pix_in_red(pix_in_red), .pix_in_blue(pix_in_blue), .pix_out_valid(pix_out_valid),
  .pix_out_red(pix_out_red), .pix_out_blue(pix_out_blue));

// File: tb/ogc_pix_src.sv
// pixel source model standing in for the overlay pipeline
`timescale 1ns/1ps
module ogc_pix_src (
  input wire logic core_clk,
  input wire logic en,
  input wire logic sweep,
  output logic pix_in_valid,
  output logic [23:0] pix
);
  logic [7:0] cnt = 8'h00;
  initial pix_in_valid = 1'b0;
  initial pix = 24'h000000;
  always @(posedge core_clk) begin
    #1;
    cnt = cnt + 8'h01;
    pix_in_valid = en && (sweep || $urandom % 4 != 0);
    if (!en) begin
      pix = ~pix;
    end else if (sweep) begin
      pix = {cnt, cnt + 8'h55, ~cnt};
    end else begin
      pix = 24'($urandom);
    end
  end
endmodule : ogc_pix_src

// File: tb/test_overlay_gamma_correction.sv
// testbench for the overlay gamma unit
`timescale 1ns/1ps
`include "ogc_map.svh"
module test_overlay_gamma_correction
  import ogc_pkg::*;
;
  localparam int XP[7] = '{0, 8, 16, 32, 64, 128, 192};
  logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, en = 0, sweep = 0, reg_rvalid, iv, ov;
  logic [19:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata;
  logic [23:0] pin, pout, e;
  logic [7:0] v;
  ogc_point_t pt[6];
  logic [24:0] hist[3] = '{default: '0};
  int num_errors = 0, comparisons = 0;
  ogc_gamma dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .pix_in_valid(iv), .pix_in_red(pin[23:16]), .pix_in_green(pin[15:8]),
    .pix_in_blue(pin[7:0]), .pix_out_valid(ov), .pix_out_red(pout[23:16]),
    .pix_out_green(pout[15:8]), .pix_out_blue(pout[7:0]));
  ogc_pix_src u_src (.core_clk(core_clk), .en(en), .sweep(sweep), .pix_in_valid(iv), .pix(pin));
  initial forever #20 core_clk = ~core_clk;
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] gf(logic [7:0] x, int l);
    int i, k, y0, y1;
    i = 0;
    for (int j = 1; j < 7; j++) begin
      if (x >= XP[j]) i = j;
    end
    y0 = i ? pt[i - 1][l * 8 +: 8] : 0;
    y1 = i < 6 ? pt[i][l * 8 +: 8] : 256;
    k = i < 2 ? 4 : (i > 3 ? 1 : 5 - i);
    return 8'(y0 + (((y1 - y0) * (((x - XP[i]) << k) & 127)) >> 7));
  endfunction : gf
  task automatic wr(logic [19:0] a, logic [31:0] d);
    @(posedge core_clk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(posedge core_clk) #1;
    reg_wr = 0;
  endtask : wr
  task automatic rd(logic [19:0] a, logic [31:0] exp);
    @(posedge core_clk) #1;
    reg_addr = a;
    reg_rd = 1;
    @(posedge core_clk) #1;
    reg_rd = 0;
    chk(reg_rvalid, 1);
    chk(reg_rdata, exp);
  endtask : rd
  task automatic summarize();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  always @(negedge core_clk) begin
    if (!rst) begin
      chk(ov, hist[1][24]);
      if (hist[1][24]) begin
        e = {gf(hist[1][23:16], 2), gf(hist[1][15:8], 1), gf(hist[1][7:0], 0)};
        chk(pout, e);
      end
    end
    hist <= '{{iv, pin}, hist[0], hist[1]};
  end
  initial begin
    #(40 * 6000);
    num_errors++;
    summarize();
  end
  initial begin
    void'($urandom(45253));
    repeat (16) @(posedge core_clk);
    #1 rst = 0;
    for (int c = 0; c < 3; c++) begin
      for (int i = 0; i < 6; i++) begin
        for (int l = 0; l < 3; l++) begin
          v = 8'(XP[i + 1] + (c > 0 ? $urandom % 8 : 0));
          if (c == 2 && l == 0) v = i == 0 ? 8'h7F : (i == 1 ? 8'hFE : 8'hFF);
          pt[i][l * 8 +: 8] = v;
        end
        if (c > 0) wr(20'(`OGC_ADDR_PT8 - 4 * i), {8'hA5, pt[i]});
      end
      wr(20'h30028, 32'hFFFFFFFF);
      rd(20'h30028, 32'h0);
      for (int i = 0; i < 6; i++) rd(20'(`OGC_ADDR_PT8 - 4 * i), {8'h00, pt[i]});
      @(posedge core_clk) #1 en = 1;
      sweep = 1;
      repeat (260) @(posedge core_clk);
      #1 sweep = 0;
      repeat (200) @(posedge core_clk);
      #1 en = 0;
      repeat (4) @(posedge core_clk);
    end
    summarize();
  end
endmodule : test_overlay_gamma_correction
